// [codec_id_map.svh]
// Purpose: Offsets, field positions and reset values of the codec identity register bank.
// Assumes: Offsets are byte offsets within the access space that selects them.
// Notes:   Definitions only; included by bare name.
`ifndef CODEC_ID_MAP_SVH
`define CODEC_ID_MAP_SVH

// Bus mastering I/O space.
`define CID_OFF_GLOBAL_CONTROL      8'h2C
`define CID_OFF_GLOBAL_STATUS       8'h30
`define CID_GCTL_LINK_RESET_BIT     1
`define CID_GCTL_RESET              16'h0000
`define CID_GSTA_PRIMARY_READY_BIT  8
`define CID_GSTA_SECONDARY_READY_BIT 9
`define CID_GSTA_RESET              16'h0000

// Function configuration space.
`define CID_OFF_SUBSYS_VENDOR       8'h2C
`define CID_OFF_SUBSYS_IDENTITY     8'h2E
`define CID_SUBSYS_RESET            16'h0000

// Controller function 0 configuration space.
`define CID_OFF_FUNCTION_HIDE       8'hF2
`define CID_HIDE_RESET              8'h00
`define CID_HIDE_MODEM_BIT          6
`define CID_HIDE_AUDIO_BIT          5

// Mixer spaces.
`define CID_OFF_MODEM_IDENTITY      8'h3C
`define CID_OFF_PRIMARY_WORD_ONE    8'h7C
`define CID_OFF_PRIMARY_WORD_TWO    8'h7E
`define CID_OFF_SECONDARY_WORD_ONE  8'hFC
`define CID_OFF_SECONDARY_WORD_TWO  8'hFE

// Vendor word field layout.
`define CID_VWORD_HIGH_MSB          15
`define CID_VWORD_HIGH_LSB          8
`define CID_VWORD_LOW_MSB           7
`define CID_VWORD_LOW_LSB           0

// Modem identity field layout.
`define CID_MID_INDEX_HIGH_BIT      15
`define CID_MID_INDEX_LOW_BIT       14
`define CID_MID_LINE_ONE_BIT        0

`define CID_UNMAPPED_READ           16'h0000

`endif

// [codec_id_pkg.sv]
// Purpose: Types shared by the codec identity register bank.
// Assumes: Nothing.
// Notes:   Constants live in codec_id_map.svh.
`default_nettype none
package codec_id_pkg;

   typedef enum logic [2:0] {
      space_fn0_config,
      space_fn_config,
      space_bus_master,
      space_audio_mixer,
      space_modem_mixer
   } space_t;

   typedef logic [15:0] word_t;

endpackage
`default_nettype wire

// [id_prog_if.sv]
// Purpose: Carries a lane-enabled write and the stored value of one write-once register.
// Assumes: Both ends run on the same clock.
// Notes:   ctrl is the decoding end, store the holding end.
`timescale 1ns/10ps
`default_nettype none
interface id_prog_if #(
   parameter int WIDTH = 16
);
   logic                 wr_stb;
   logic [WIDTH-1:0]     wr_data;
   logic [WIDTH/8-1:0]   wr_be;
   logic [WIDTH-1:0]     value;
   logic                 locked;

   modport ctrl  (output wr_stb, output wr_data, output wr_be, input value, input locked);
   modport store (input wr_stb, input wr_data, input wr_be, output value, output locked);
endinterface
`default_nettype wire

// [level_sync.sv]
// Purpose: Two-flop synchroniser for a group of asynchronous levels.
// Assumes: Each bit is a slow level; no bits need to stay coherent with each other.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : gen_bit
         logic stage1_ff;
         logic stage2_ff;
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               stage1_ff <= 1'b0;
               stage2_ff <= 1'b0;
            end else begin
               stage1_ff <= async_in[g];
               stage2_ff <= stage1_ff;
            end
         end
         assign sync_out[g] = stage2_ff;
      end
   endgenerate
endmodule
`default_nettype wire

// [write_once_reg.sv]
// Purpose: Register that takes one software programming after each system reset.
// Assumes: A write with at least one lane enabled counts as the programming.
// Notes:   Lanes not enabled in that write keep the reset value for good.
`timescale 1ns/10ps
`default_nettype none
`include "codec_id_map.svh"
module write_once_reg #(
   parameter int           WIDTH     = 16,
   parameter logic [15:0]  RESET_VAL = `CID_SUBSYS_RESET
) (
   input  wire logic clk,
   input  wire logic arst_n,
   id_prog_if.store  port
);
   logic [WIDTH-1:0] value_ff;
   logic [WIDTH-1:0] nxt_value;
   logic             locked_ff;
   logic             nxt_locked;
   logic             take;

   always_comb begin
      take       = port.wr_stb && !locked_ff && (|port.wr_be);
      nxt_value  = value_ff;
      nxt_locked = locked_ff;
      if (take) begin
         for (int i = 0; i < WIDTH/8; i++) begin
            if (port.wr_be[i]) begin
               nxt_value[i*8 +: 8] = port.wr_data[i*8 +: 8];
            end
         end
         nxt_locked = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         value_ff  <= RESET_VAL[WIDTH-1:0];
         locked_ff <= 1'b0;
      end else begin
         value_ff  <= nxt_value;
         locked_ff <= nxt_locked;
      end
   end

   assign port.value  = value_ff;
   assign port.locked = locked_ff;
endmodule
`default_nettype wire

// [codec_id_subsys_regs.sv]
// Purpose: Register bank used while software enumerates the serial-link codecs.
// Assumes: Vendor and modem identity words arrive from the link frame engine on clk.
//          Codec ready levels come from the link side and are synchronised here.
// Notes:   One access per request; reads answer one cycle later with registered data.
`timescale 1ns/10ps
`default_nettype none
`include "codec_id_map.svh"

////////////////////////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R01 - Status bit 9 shows secondary codec ready.
// R02 - Subsystem vendor identity: zero reset, write once.
// R03 - Subsystem identity: zero reset, write once.
// R04 - Secondary word one read at FCh.
// R05 - Secondary word two read at FEh.
// R06 - Primary words at 7Ch/7Eh, both mixers.
// R07 - Words carry two characters, or character plus revision.
// R08 - Software detects modem from identity at 3Ch.
// R09 - Software resets link, hides missing modem.
// R10 - Software programs identity from secondary words.
// R11 - Status bit 8 shows primary codec ready.
// R12 - Control bit 1 releases link reset.
// R13 - Hide bits 6 and 5 conceal functions.
// R14 - Later identity writes ignored until reset.
module codec_id_subsys_regs (
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   input  wire codec_id_pkg::space_t req_space,
   input  wire logic [7:0]           req_addr,
   input  wire logic                 req_wr,
   input  wire logic                 req_rd,
   input  wire logic [1:0]           req_be,
   input  wire logic [15:0]          req_wdata,
   output logic                      rsp_valid,
   output logic [15:0]               rsp_rdata,
   input  wire logic                 primary_codec_ready_in,
   input  wire logic                 secondary_codec_ready_in,
   input  wire codec_id_pkg::word_t  modem_function_identity_in,
   input  wire codec_id_pkg::word_t  primary_vendor_word_one_in,
   input  wire codec_id_pkg::word_t  primary_vendor_word_two_in,
   input  wire codec_id_pkg::word_t  secondary_vendor_word_one_in,
   input  wire codec_id_pkg::word_t  secondary_vendor_word_two_in,
   output logic                      codec_link_reset_n,
   output logic                      hide_modem_function,
   output logic                      hide_audio_function,
   output logic [15:0]               subsystem_vendor_identity,
   output logic [15:0]               subsystem_identity,
   output logic [1:0]                subsystem_locked
);

   /////////////////////////////////////////////////////////////////////////////////////////////////
   // Address decode.

   function automatic logic hit(
      input codec_id_pkg::space_t sp,
      input logic [7:0]           addr,
      input codec_id_pkg::space_t want_sp,
      input logic [7:0]           want_off
   );
      hit = (sp == want_sp) && (addr == want_off);
   endfunction

   logic hit_gctl;
   logic hit_gsta;
   logic hit_subsystem_vendor_identity;
   logic hit_subsystem_identity;
   logic hit_hide;
   logic hit_mid;
   logic hit_pw1;
   logic hit_pw2;
   logic hit_sw1;
   logic hit_sw2;

   always_comb begin
      hit_gctl  = hit(req_space, req_addr, codec_id_pkg::space_bus_master,
                      `CID_OFF_GLOBAL_CONTROL);
      hit_gsta  = hit(req_space, req_addr, codec_id_pkg::space_bus_master,
                      `CID_OFF_GLOBAL_STATUS);
      hit_subsystem_vendor_identity = hit(req_space, req_addr, codec_id_pkg::space_fn_config,
                      `CID_OFF_SUBSYS_VENDOR);
      hit_subsystem_identity  = hit(req_space, req_addr, codec_id_pkg::space_fn_config,
                      `CID_OFF_SUBSYS_IDENTITY);
      hit_hide  = hit(req_space, req_addr, codec_id_pkg::space_fn0_config,
                      `CID_OFF_FUNCTION_HIDE);
      hit_mid   = hit(req_space, req_addr, codec_id_pkg::space_modem_mixer,
                      `CID_OFF_MODEM_IDENTITY);
      // The primary words answer at the same offsets in either mixer space.
      hit_pw1   = hit(req_space, req_addr, codec_id_pkg::space_audio_mixer,
                      `CID_OFF_PRIMARY_WORD_ONE)
               || hit(req_space, req_addr, codec_id_pkg::space_modem_mixer,
                      `CID_OFF_PRIMARY_WORD_ONE);                        // see R06
      hit_pw2   = hit(req_space, req_addr, codec_id_pkg::space_audio_mixer,
                      `CID_OFF_PRIMARY_WORD_TWO)
               || hit(req_space, req_addr, codec_id_pkg::space_modem_mixer,
                      `CID_OFF_PRIMARY_WORD_TWO);                        // see R06
      hit_sw1   = hit(req_space, req_addr, codec_id_pkg::space_modem_mixer,
                      `CID_OFF_SECONDARY_WORD_ONE);                      // see R04
      hit_sw2   = hit(req_space, req_addr, codec_id_pkg::space_modem_mixer,
                      `CID_OFF_SECONDARY_WORD_TWO);                      // see R05
   end

   /////////////////////////////////////////////////////////////////////////////////////////////////
   // Codec ready levels from the link side.

   logic [1:0] ready_sync;

   level_sync #(
      .WIDTH (2)
   ) u_ready_sync (
      .clk      (clk),
      .arst_n   (arst_n),
      .async_in ({secondary_codec_ready_in, primary_codec_ready_in}),
      .sync_out (ready_sync)
   );

   logic [15:0] global_status_word;

   always_comb begin
      global_status_word = `CID_GSTA_RESET;
      global_status_word[`CID_GSTA_PRIMARY_READY_BIT]   = ready_sync[0];   // see R11
      global_status_word[`CID_GSTA_SECONDARY_READY_BIT] = ready_sync[1];   // see R01
   end

   /////////////////////////////////////////////////////////////////////////////////////////////////
   // Global control and function hide.

   logic [15:0] global_control_ff;
   logic [15:0] nxt_global_control;
   logic [7:0]  hide_ff;
   logic [7:0]  nxt_hide;

   always_comb begin
      nxt_global_control = global_control_ff;
      nxt_hide           = hide_ff;
      // Only the link reset bit is kept; the rest of the word reads as zero.
      if (req_wr && hit_gctl && req_be[0]) begin
         nxt_global_control[`CID_GCTL_LINK_RESET_BIT] =
            req_wdata[`CID_GCTL_LINK_RESET_BIT];                           // see R12
      end
      // Every bit of the hide byte is kept, so software can preserve its neighbours.
      if (req_wr && hit_hide && req_be[0]) begin
         nxt_hide = req_wdata[7:0];                                        // see R13
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         global_control_ff <= `CID_GCTL_RESET;
         hide_ff           <= `CID_HIDE_RESET;
      end else begin
         global_control_ff <= nxt_global_control;
         hide_ff           <= nxt_hide;
      end
   end

   // A zero in the control bit holds the codecs in reset, so reset leaves the link quiet.
   assign codec_link_reset_n  = global_control_ff[`CID_GCTL_LINK_RESET_BIT];     // see R12
   assign hide_modem_function = hide_ff[`CID_HIDE_MODEM_BIT];                    // see R13
   assign hide_audio_function = hide_ff[`CID_HIDE_AUDIO_BIT];                    // see R13

   /////////////////////////////////////////////////////////////////////////////////////////////////
   // Write-once subsystem identity registers.

   id_prog_if #(.WIDTH(16)) subsystem_vendor_identity_if ();
   id_prog_if #(.WIDTH(16)) subsystem_identity_if ();

   assign subsystem_vendor_identity_if.wr_stb  = req_wr && hit_subsystem_vendor_identity;                      // see R02
   assign subsystem_vendor_identity_if.wr_data = req_wdata;
   assign subsystem_vendor_identity_if.wr_be   = req_be;
   assign subsystem_identity_if.wr_stb   = req_wr && hit_subsystem_identity;                       // see R03
   assign subsystem_identity_if.wr_data  = req_wdata;
   assign subsystem_identity_if.wr_be    = req_be;

   // The stores lock on their first write with at least one lane enabled and drop later ones until reset.
   write_once_reg #(
      .WIDTH     (16),
      .RESET_VAL (`CID_SUBSYS_RESET)
   ) u_subsystem_vendor_identity (
      .clk    (clk),
      .arst_n (arst_n),
      .port   (subsystem_vendor_identity_if)
   );                                                                  // see R14

   write_once_reg #(
      .WIDTH     (16),
      .RESET_VAL (`CID_SUBSYS_RESET)
   ) u_subsystem_identity (
      .clk    (clk),
      .arst_n (arst_n),
      .port   (subsystem_identity_if)
   );                                                                  // see R14

   assign subsystem_vendor_identity = subsystem_vendor_identity_if.value;
   assign subsystem_identity        = subsystem_identity_if.value;
   assign subsystem_locked          = {subsystem_identity_if.locked, subsystem_vendor_identity_if.locked};

   /////////////////////////////////////////////////////////////////////////////////////////////////
   // Read path.

   logic        rsp_valid_ff;
   logic        nxt_rsp_valid;
   logic [15:0] rsp_rdata_ff;
   logic [15:0] nxt_rsp_rdata;
   logic [15:0] rd_word;

   // The vendor words pass through whole: high byte is the first character,
   // low byte the second character or the revision.
   always_comb begin
      rd_word = `CID_UNMAPPED_READ;
      if (hit_gctl) begin
         rd_word = global_control_ff;
      end else if (hit_gsta) begin
         rd_word = global_status_word;                                 // see R01
      end else if (hit_subsystem_vendor_identity) begin
         rd_word = subsystem_vendor_identity_if.value;                                     // see R02
      end else if (hit_subsystem_identity) begin
         rd_word = subsystem_identity_if.value;                                      // see R03
      end else if (hit_hide) begin
         rd_word = {8'h00, hide_ff};
      end else if (hit_mid) begin
         rd_word = modem_function_identity_in;
      end else if (hit_pw1) begin
         rd_word = primary_vendor_word_one_in;                         // see R07
      end else if (hit_pw2) begin
         rd_word = primary_vendor_word_two_in;                         // see R07
      end else if (hit_sw1) begin
         rd_word = secondary_vendor_word_one_in;                       // see R04
      end else if (hit_sw2) begin
         rd_word = secondary_vendor_word_two_in;                       // see R05
      end
   end

   always_comb begin
      nxt_rsp_valid = req_rd;
      nxt_rsp_rdata = rsp_rdata_ff;
      if (req_rd) begin
         nxt_rsp_rdata = rd_word;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rsp_valid_ff <= 1'b0;
         rsp_rdata_ff <= `CID_UNMAPPED_READ;
      end else begin
         rsp_valid_ff <= nxt_rsp_valid;
         rsp_rdata_ff <= nxt_rsp_rdata;
      end
   end

   assign rsp_valid = rsp_valid_ff;
   assign rsp_rdata = rsp_rdata_ff;

endmodule
`default_nettype wire

// [codec_link_model.sv]
// Purpose: Behavioural model of the codecs on the primary and secondary serial inputs.
// Assumes: Word levels are presented on the bank's clock.
// Notes:   DELAY sets how slowly a codec reports ready after link reset release.
`timescale 1ns/10ps
`default_nettype none
module codec_link_model #(
   parameter int DELAY = 6
) (
   input  wire logic          clk,
   input  wire logic          codec_link_reset_n,
   input  wire logic [1:0]    present,
   output logic      [1:0]    ready,
   output codec_id_pkg::word_t mid,
   output codec_id_pkg::word_t pw1,
   output codec_id_pkg::word_t pw2,
   output codec_id_pkg::word_t sw1,
   output codec_id_pkg::word_t sw2
);
   int cnt = 0;

   // A codec only comes ready some time after the link reset is released.
   always @(posedge clk or negedge codec_link_reset_n) begin
      if (!codec_link_reset_n) cnt <= 0;
      else if (cnt < DELAY) cnt <= cnt + 1;
   end
   assign ready = (cnt >= DELAY) ? present : 2'h0;
   assign mid   = 16'h0001;
   assign pw1   = 16'h5152;
   assign pw2   = 16'h5307;
   assign sw1   = 16'h4D44;
   assign sw2   = 16'h4E21;
endmodule
`default_nettype wire

// [codec_id_subsys_regs_props.sv]
// Purpose: Port checks for the codec identity register bank.
// Assumes: One clock; reads answer one cycle after the request edge.
// Notes:   Bound to the bank after the module.
`timescale 1ns/10ps
`default_nettype none
module codec_id_subsys_regs_props (
   input wire logic                 clk, arst_n, req_wr, req_rd, rsp_valid,
   input wire logic                 primary_codec_ready_in, secondary_codec_ready_in,
   input wire logic                 codec_link_reset_n, hide_modem_function, hide_audio_function,
   input wire codec_id_pkg::space_t req_space,
   input wire logic [7:0]           req_addr,
   input wire logic [1:0]           req_be, subsystem_locked,
   input wire logic [15:0]          req_wdata, rsp_rdata, subsystem_vendor_identity,
   input wire logic [15:0]          subsystem_identity,
   input wire codec_id_pkg::word_t  primary_vendor_word_one_in, primary_vendor_word_two_in,
   input wire codec_id_pkg::word_t  secondary_vendor_word_one_in, secondary_vendor_word_two_in
);
   logic [1:0]  age_ff, nxt_age, rdy;
   logic [15:0] lane;
   logic        mx, mm, bm, fc, f0;

   assign rdy  = {secondary_codec_ready_in, primary_codec_ready_in};
   assign lane = req_wdata & {{8{req_be[1]}}, {8{req_be[0]}}};
   assign mm   = req_space == codec_id_pkg::space_modem_mixer;
   assign mx   = mm || req_space == codec_id_pkg::space_audio_mixer;
   assign bm   = req_space == codec_id_pkg::space_bus_master;
   assign fc   = req_space == codec_id_pkg::space_fn_config;
   assign f0   = req_space == codec_id_pkg::space_fn0_config;

   // The synchroniser needs a few edges after reset before status is meaningful.
   always_comb nxt_age = (age_ff == 2'h3) ? age_ff : age_ff + 2'h1;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) age_ff <= 2'h0;
      else age_ff <= nxt_age;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   a_read_answer: assert property (req_rd |=> rsp_valid)
      else $error("Read not answered one cycle later.");
   a_stray_answer: assert property (!req_rd |=> !rsp_valid)
      else $error("Answer without a read.");
   a_second_one: assert property (req_rd && mm && req_addr == 8'hFC
      |=> rsp_rdata == $past(secondary_vendor_word_one_in)) else $error("Bad FC word.");
   a_second_two: assert property (req_rd && mm && req_addr == 8'hFE
      |=> rsp_rdata == $past(secondary_vendor_word_two_in)) else $error("Bad FE word.");
   a_primary_words: assert property (req_rd && mx && req_addr[7:2] == 6'h1F
      && !req_addr[0] |=> rsp_rdata == ($past(req_addr[1]) ? $past(primary_vendor_word_two_in)
                                                            : $past(primary_vendor_word_one_in)))
      else $error("Bad primary word.");
   a_ready_status: assert property (req_rd && bm && req_addr == 8'h30 && age_ff == 2'h3
      && rdy == $past(rdy) && rdy == $past(rdy, 2) |=> rsp_rdata == {6'h00, $past(rdy), 8'h00})
      else $error("Bad ready status.");
   a_link_reset: assert property (req_wr && bm && req_addr == 8'h2C && req_be[0]
      |=> codec_link_reset_n == $past(req_wdata[1])) else $error("Link reset not set.");
   a_hide_bits: assert property (req_wr && f0 && req_addr == 8'hF2 && req_be[0]
      |=> {hide_modem_function, hide_audio_function} == $past(req_wdata[6:5]))
      else $error("Hide bits not set.");
   a_vendor_first: assert property (req_wr && fc && req_addr == 8'h2C && req_be != 2'h0
      && !subsystem_locked[0] |=> subsystem_locked[0] && subsystem_vendor_identity == $past(lane))
      else $error("Vendor identity not taken.");
   a_ident_first: assert property (req_wr && fc && req_addr == 8'h2E && req_be != 2'h0
      && !subsystem_locked[1] |=> subsystem_locked[1] && subsystem_identity == $past(lane))
      else $error("Identity not taken.");
   a_vendor_held: assert property (subsystem_locked[0]
      |=> subsystem_locked[0] && $stable(subsystem_vendor_identity)) else $error("Vendor moved.");
   a_ident_held: assert property (subsystem_locked[1]
      |=> subsystem_locked[1] && $stable(subsystem_identity)) else $error("Identity moved.");

   c_status: cover property (req_rd && bm && req_addr == 8'h30 ##1 rsp_rdata[9]);
   c_relock: cover property (subsystem_locked[0] && req_wr && fc && req_addr == 8'h2C);
   c_word_two: cover property (req_rd && mm && req_addr == 8'hFE);
endmodule

bind codec_id_subsys_regs codec_id_subsys_regs_props codec_id_subsys_regs_props_inst (.*);
`default_nettype wire

// [codec_id_subsys_regs_tb.sv]
// Purpose: Self-checking bench for the codec identity register bank.
// Assumes: The codec model stands on the link side.
// Notes:   Every read answer and register level is compared with a bench model.
`timescale 1ns/10ps
`default_nettype none
module codec_id_subsys_regs_tb;
   localparam codec_id_pkg::space_t F0 = codec_id_pkg::space_fn0_config;
   localparam codec_id_pkg::space_t FN = codec_id_pkg::space_fn_config;
   localparam codec_id_pkg::space_t BM = codec_id_pkg::space_bus_master;
   localparam codec_id_pkg::space_t AM = codec_id_pkg::space_audio_mixer;
   localparam codec_id_pkg::space_t MM = codec_id_pkg::space_modem_mixer;
   localparam int DELAY = 6;
   logic                 clk = 1'b0, arst_n = 1'b0, req_wr = 1'b0, req_rd = 1'b0;
   logic                 rsp_valid, link_n, hm, ha;
   codec_id_pkg::space_t req_space = F0;
   logic [7:0]           req_addr = 8'h00;
   logic [1:0]           req_be = 2'h0, present = 2'h0, rdy, lk, m_lk;
   logic [15:0]          req_wdata = 16'h0000, rsp_rdata, sv, si, m_sv, m_si;
   logic [7:0]           m_hide;
   logic                 m_ctrl;
   codec_id_pkg::word_t  mid, pw1, pw2, sw1, sw2;
   int                   seed = 93, miscompares = 0, total_checks = 0;
   codec_id_pkg::space_t tsp [13] = '{BM, BM, F0, FN, FN, MM, AM, AM, MM, MM, MM, MM, AM};
   logic [7:0] tad [13] = '{8'h2C, 8'h30, 8'hF2, 8'h2C, 8'h2E, 8'h3C, 8'h7C, 8'h7E, 8'h7C,
                            8'h7E, 8'hFC, 8'hFE, 8'hFC};

   always #5 clk = ~clk;

   codec_id_subsys_regs codec_id_subsys_regs_inst (
      .clk, .arst_n, .req_space, .req_addr, .req_wr, .req_rd, .req_be, .req_wdata, .rsp_valid,
      .rsp_rdata, .primary_codec_ready_in(rdy[0]), .secondary_codec_ready_in(rdy[1]),
      .modem_function_identity_in(mid), .primary_vendor_word_one_in(pw1),
      .primary_vendor_word_two_in(pw2), .secondary_vendor_word_one_in(sw1),
      .secondary_vendor_word_two_in(sw2), .codec_link_reset_n(link_n),
      .hide_modem_function(hm), .hide_audio_function(ha), .subsystem_vendor_identity(sv),
      .subsystem_identity(si), .subsystem_locked(lk));
   codec_link_model #(.DELAY(DELAY)) codec_link_model_inst (
      .clk, .codec_link_reset_n(link_n), .present, .ready(rdy), .mid, .pw1, .pw2, .sw1, .sw2);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] exp_word(input codec_id_pkg::space_t s, input logic [7:0] a);
      logic mx;
      mx = (s == AM) || (s == MM);
      if (s == BM && a == 8'h2C) return {14'h0000, m_ctrl, 1'b0};
      if (s == BM && a == 8'h30) return {6'h00, rdy, 8'h00};
      if (s == F0 && a == 8'hF2) return {8'h00, m_hide};
      if (s == FN && a == 8'h2C) return m_sv;
      if (s == FN && a == 8'h2E) return m_si;
      if (s == MM && a == 8'h3C) return mid;
      if (mx && a == 8'h7C) return pw1;
      if (mx && a == 8'h7E) return pw2;
      if (s == MM && a == 8'hFC) return sw1;
      if (s == MM && a == 8'hFE) return sw2;
      return 16'h0000;
   endfunction

   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] want, input string what);
      total_checks++;
      if (got !== want) begin
         miscompares++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, want);
      end
   endtask

   // One request; writes update the model, reads compare the answer.
   task automatic issue(input codec_id_pkg::space_t s, input logic [7:0] a, input logic w,
                        input logic [1:0] be, input logic [15:0] d);
      logic [15:0] e;
      int          n;
      @(posedge clk);
      req_space <= s;
      req_addr <= a;
      req_be <= be;
      req_wdata <= d;
      req_wr <= w;
      req_rd <= !w;
      @(posedge clk);
      e = exp_word(s, a);
      req_wr <= 1'b0;
      req_rd <= 1'b0;
      if (w) begin
         if (s == BM && a == 8'h2C && be[0]) m_ctrl = d[1];
         if (s == F0 && a == 8'hF2 && be[0]) m_hide = d[7:0];
         if (s == FN && a[7:2] == 6'h0B && !a[0] && be != 2'h0 && !m_lk[a[1]]) begin
            m_lk[a[1]] = 1'b1;
            e = d & {{8{be[1]}}, {8{be[0]}}};
            if (a[1]) m_si = e;
            else m_sv = e;
         end
         @(posedge clk);
         #1;
         chk(16'({link_n, hm, ha, lk}), 16'({m_ctrl, m_hide[6:5], m_lk}), "levels");
         chk(sv, m_sv, "vendor identity");
         chk(si, m_si, "identity");
      end else begin
         n = 0;
         #1;
         while (rsp_valid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
         end
         if (n == 4) begin
            miscompares++;
            $display("CHECK FAILED t=%0t no read answer", $time);
            conclude();
         end else begin
            chk(rsp_rdata, e, "read data");
         end
      end
   endtask

   task automatic do_reset;
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      {m_ctrl, m_hide, m_sv, m_si, m_lk} = '0;
   endtask

   initial begin
      int          k;
      logic [15:0] d;
      do_reset();
      for (int i = 0; i < 13; i++) issue(tsp[i], tad[i], 1'b0, 2'h0, 16'h0000);
      $display("test reset_values done");
      present <= 2'h1;
      issue(BM, 8'h2C, 1'b1, 2'h1, 16'h0002);
      issue(BM, 8'h2C, 1'b1, 2'h2, 16'h0000);
      repeat (DELAY + 4) @(posedge clk);
      issue(BM, 8'h30, 1'b0, 2'h0, 16'h0000);
      issue(MM, 8'h3C, 1'b0, 2'h0, 16'h0000);
      issue(BM, 8'h2C, 1'b1, 2'h1, 16'h0000);
      issue(BM, 8'h2C, 1'b1, 2'h3, 16'h0002);
      issue(F0, 8'hF2, 1'b1, 2'h1, 16'h0040);
      issue(F0, 8'hF2, 1'b1, 2'h1, 16'h0020);
      present <= 2'h3;
      repeat (DELAY + 4) @(posedge clk);
      issue(BM, 8'h30, 1'b0, 2'h0, 16'h0000);
      issue(MM, 8'hFC, 1'b1, 2'h3, 16'($random(seed)));
      for (int i = 10; i < 13; i++) issue(tsp[i], tad[i], 1'b0, 2'h0, 16'h0000);
      issue(FN, 8'h2C, 1'b1, 2'h3, sw1);
      issue(FN, 8'h2E, 1'b1, 2'h3, sw2);
      $display("test enumeration done");
      for (int i = 0; i < 60; i++) begin
         k = {$random(seed)} % 13;
         d = 16'($random(seed));
         issue(tsp[k], tad[k], d[15], d[3:2], d | 16'h0002);
      end
      $display("test random_traffic done");
      do_reset();
      issue(BM, 8'h30, 1'b0, 2'h0, 16'h0000);
      issue(FN, 8'h2C, 1'b1, 2'h1, 16'hA5C3);
      issue(FN, 8'h2E, 1'b1, 2'h0, 16'h1234);
      issue(FN, 8'h2E, 1'b1, 2'h2, 16'h5A69);
      issue(FN, 8'h2E, 1'b1, 2'h3, 16'hFFFF);
      for (int i = 3; i < 5; i++) issue(tsp[i], tad[i], 1'b0, 2'h0, 16'h0000);
      $display("test second_reset done");
      conclude();
   end
endmodule
`default_nettype wire
